/* File: twm_pkg.sv */
package twm_pkg;
  // Register word addresses (byte offsets on APB)
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_DATA    = 8'h08;
  localparam logic [7:0] ADDR_BITRATE = 8'h0c;
  // Control field positions
  localparam int CTL_FLAG  = 7;
  localparam int CTL_ACKEN = 6;
  localparam int CTL_STA   = 5;
  localparam int CTL_STO   = 4;
  localparam int CTL_WCOL  = 3;
  localparam int CTL_EN    = 2;
  localparam int CTL_IE    = 0;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET    = 8'hff;
  // Status field: code in [7:3], low bits [2:0] masked
  localparam logic [7:0] STATUS_MASK   = 8'hf8;
  localparam logic [7:0] ST_START      = 8'h08;
  localparam logic [7:0] ST_RSTART     = 8'h10;
  localparam logic [7:0] ST_AW_ACK     = 8'h18;
  localparam logic [7:0] ST_AW_NACK    = 8'h20;
  localparam logic [7:0] ST_DATA_ACK   = 8'h28;
  localparam logic [7:0] ST_DATA_NACK  = 8'h30;
  localparam logic [7:0] ST_ARB_LOST   = 8'h38;
  localparam logic [7:0] ST_AR_ACK     = 8'h40;
  localparam logic [7:0] ST_AR_NACK    = 8'h48;
  localparam logic [7:0] ST_IDLE       = 8'hf8;
  // Quarter-bit period minus one in mclk cycles (default 104 mclk per bit, about 96 kHz at 10 MHz)
  localparam logic [7:0] BITRATE_RESET = 8'h19;
  localparam int         BIT_COUNT_W   = 4;

  typedef enum logic [8:0] {
    TWM_IDLE  = 9'b000000001,
    TWM_WAIT  = 9'b000000010,
    TWM_START = 9'b000000100,
    TWM_HOLD  = 9'b000001000,
    TWM_BIT   = 9'b000010000,
    TWM_ACK   = 9'b000100000,
    TWM_STOP  = 9'b001000000,
    TWM_RSTA  = 9'b010000000,
    TWM_SLAVE = 9'b100000000
  } twm_state_t;
endpackage : twm_pkg

/* File: twm_sync.sv */
`timescale 1ns/10ps
`default_nettype none
// ************************************************
// Two-flop synchroniser for bus lines
// ************************************************
module twm_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_ff <= '1;
      sync_ff <= '1;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule : twm_sync
`default_nettype wire

/* File: twm_master.sv */
`timescale 1ns/10ps
`default_nettype none
module twm_master (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             irq,
  output logic             master_receive_mode
);
  import twm_pkg::*;

  // ************************************************
  // Bus line sampling
  // ************************************************
  logic [1:0] line_sync;
  logic       scl_s;
  logic       sda_s;
  logic       scl_d_ff;
  logic       sda_d_ff;
  logic       bus_busy_ff;

  twm_sync #(.WIDTH(2)) u_sync (
    .mclk     (mclk),
    .rst      (rst),
    .async_in ({scl_in, sda_in}),
    .sync_out (line_sync)
  );
  assign scl_s = line_sync[1];
  assign sda_s = line_sync[0];

  wire seen_start = scl_s && scl_d_ff && sda_d_ff && !sda_s;
  wire seen_stop  = scl_s && scl_d_ff && !sda_d_ff && sda_s;

  // ************************************************
  // Registers and APB decode
  // ************************************************
  logic [7:0] control_ff;
  logic [7:0] status_ff;
  logic [7:0] data_ff;
  logic [7:0] bitrate_ff;
  twm_state_t state_ff;
  twm_state_t nxt_state;

  wire access   = psel && penable;
  wire wr_ctl   = access && pwrite && (paddr == ADDR_CONTROL);
  wire wr_data  = access && pwrite && (paddr == ADDR_DATA);
  wire wr_rate  = access && pwrite && (paddr == ADDR_BITRATE);
  wire addr_ok  = (paddr == ADDR_CONTROL) || (paddr == ADDR_STATUS) ||
                  (paddr == ADDR_DATA) || (paddr == ADDR_BITRATE);
  wire flag     = control_ff[CTL_FLAG];
  wire enable   = control_ff[CTL_EN];
  wire flag_clr = wr_ctl && pwdata[CTL_FLAG];
  wire data_ok  = wr_data && flag;
  wire data_col = wr_data && !flag;

  function automatic logic status_is(input logic [7:0] st, input logic [7:0] code);
    status_is = (st & STATUS_MASK) == code;
  endfunction : status_is

  assign pready  = 1'b1;
  assign pslverr = access && !addr_ok;
  assign irq     = control_ff[CTL_IE] && flag;  // Interrupt request

  always_comb begin
    case (paddr)
      ADDR_CONTROL: prdata = {24'h000000, control_ff};
      ADDR_STATUS:  prdata = {24'h000000, status_ff & STATUS_MASK};
      ADDR_DATA:    prdata = {24'h000000, data_ff};
      ADDR_BITRATE: prdata = {24'h000000, bitrate_ff};
      default:      prdata = 32'h00000000;
    endcase
  end

  // ************************************************
  // Quarter-bit tick divider
  // ************************************************
  logic [7:0] div_ff;
  wire        tick = (div_ff == 8'h00);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) div_ff <= 8'h00;
    else if (tick) div_ff <= bitrate_ff;
    else div_ff <= div_ff - 8'h01;
  end

  // ************************************************
  // Bit engine
  // ************************************************
  logic [1:0]             phase_ff;
  logic [BIT_COUNT_W-1:0] bit_ff;
  logic                   is_addr_ff;
  logic                   rd_addr_ff;
  logic                   restart_ff;
  logic                   hw_flag;
  logic [7:0]             hw_status;
  logic                   sda_drv_ff;
  logic                   scl_drv_ff;
  logic                   sto_done;
  logic                   rx_mode_ff;

  wire q_end  = tick && (phase_ff == 2'd3);
  wire my_bit = data_ff[7];
  // Arbitration lost: released line read low while clock high
  wire arb_lost = (state_ff == TWM_BIT) && tick && (phase_ff == 2'd2) && sda_drv_ff && !sda_s;

  always_comb begin
    nxt_state = state_ff;
    hw_flag   = 1'b0;
    hw_status = status_ff;
    sto_done  = 1'b0;
    case (state_ff)
      TWM_IDLE: begin
        // Start request waits for free bus
        if (enable && !flag && control_ff[CTL_STA]) nxt_state = TWM_WAIT;
      end
      TWM_WAIT: begin
        if (!bus_busy_ff && q_end) nxt_state = TWM_START;
      end
      TWM_START: begin
        if (q_end) begin
          hw_flag   = 1'b1;
          hw_status = restart_ff ? ST_RSTART : ST_START;
          nxt_state = TWM_HOLD;
        end
      end
      TWM_HOLD: begin
        if (!flag) begin
          if (control_ff[CTL_STO]) nxt_state = TWM_STOP;
          else if (control_ff[CTL_STA] && !status_is(status_ff, ST_START))
            nxt_state = TWM_RSTA;
          else nxt_state = TWM_BIT;
        end
      end
      TWM_BIT: begin
        if (arb_lost) begin
          hw_flag   = 1'b1;
          hw_status = ST_ARB_LOST;
          nxt_state = TWM_SLAVE;
        end else if (q_end && bit_ff == 4'd7) nxt_state = TWM_ACK;
      end
      TWM_ACK: begin
        if (q_end) begin
          hw_flag = 1'b1;
          if (is_addr_ff && !rd_addr_ff) hw_status = sda_s ? ST_AW_NACK : ST_AW_ACK;
          else if (is_addr_ff) hw_status = sda_s ? ST_AR_NACK : ST_AR_ACK;
          else hw_status = sda_s ? ST_DATA_NACK : ST_DATA_ACK;
          nxt_state = TWM_HOLD;
        end
      end
      TWM_STOP: begin
        if (q_end) begin
          sto_done  = 1'b1;
          nxt_state = control_ff[CTL_STA] ? TWM_WAIT : TWM_IDLE;
        end
      end
      TWM_RSTA: begin
        if (q_end) nxt_state = TWM_START;
      end
      TWM_SLAVE: begin
        if (!flag) nxt_state = control_ff[CTL_STA] ? TWM_WAIT : TWM_IDLE;
      end
      default: nxt_state = TWM_IDLE;
    endcase
    if (!enable) nxt_state = TWM_IDLE;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_ff   <= TWM_IDLE;
      phase_ff   <= 2'd0;
      bit_ff     <= '0;
      is_addr_ff <= 1'b0;
      rd_addr_ff <= 1'b0;
      restart_ff <= 1'b0;
      rx_mode_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (nxt_state != state_ff) phase_ff <= 2'd0;
      else if (tick) phase_ff <= phase_ff + 2'd1;
      if (state_ff == TWM_HOLD && nxt_state == TWM_BIT) begin
        bit_ff     <= '0;
        is_addr_ff <= status_is(status_ff, ST_START) || status_is(status_ff, ST_RSTART);
        rd_addr_ff <= data_ff[0];
      end else if (state_ff == TWM_BIT && q_end) begin
        bit_ff <= bit_ff + 4'd1;
      end
      if (nxt_state == TWM_RSTA) restart_ff <= 1'b1;
      else if (nxt_state == TWM_IDLE || nxt_state == TWM_WAIT) restart_ff <= 1'b0;
      if (nxt_state == TWM_IDLE || nxt_state == TWM_START || nxt_state == TWM_SLAVE)
        rx_mode_ff <= 1'b0;
      else if (state_ff == TWM_ACK && q_end && is_addr_ff)
        rx_mode_ff <= rd_addr_ff;
    end
  end

  // Line drive per state and quarter
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      scl_drv_ff <= 1'b1;
      sda_drv_ff <= 1'b1;
    end else begin
      case (state_ff)
        TWM_START: begin
          sda_drv_ff <= 1'b0;
          scl_drv_ff <= (phase_ff < 2'd2);
        end
        // MSB first, ninth clock samples ack
        TWM_BIT: begin
          sda_drv_ff <= my_bit;
          scl_drv_ff <= (phase_ff == 2'd1) || (phase_ff == 2'd2);
        end
        TWM_ACK: begin
          sda_drv_ff <= 1'b1;
          scl_drv_ff <= (phase_ff == 2'd1) || (phase_ff == 2'd2);
        end
        TWM_STOP: begin
          sda_drv_ff <= (phase_ff >= 2'd2);
          scl_drv_ff <= (phase_ff >= 2'd1);
        end
        TWM_RSTA: begin
          sda_drv_ff <= 1'b1;
          scl_drv_ff <= (phase_ff >= 2'd1);
        end
        TWM_HOLD: begin
          sda_drv_ff <= sda_drv_ff;
          scl_drv_ff <= 1'b0;
        end
        default: begin
          sda_drv_ff <= 1'b1;
          scl_drv_ff <= 1'b1;
        end
      endcase
    end
  end

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe  = !scl_drv_ff;
  assign sda_oe  = !sda_drv_ff;
  assign master_receive_mode = rx_mode_ff;

  // ************************************************
  // Register updates
  // ************************************************
  wire shift = (state_ff == TWM_BIT) && q_end && !arb_lost;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      control_ff  <= CONTROL_RESET;
      status_ff   <= ST_IDLE;
      data_ff     <= DATA_RESET;
      bitrate_ff  <= BITRATE_RESET;
      scl_d_ff    <= 1'b1;
      sda_d_ff    <= 1'b1;
      bus_busy_ff <= 1'b0;
    end else begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
      if (seen_start) bus_busy_ff <= 1'b1;
      else if (seen_stop) bus_busy_ff <= 1'b0;
      if (wr_rate) bitrate_ff <= pwdata[7:0];
      status_ff <= hw_status;
      if (data_ok) data_ff <= pwdata[7:0];
      else if (shift) data_ff <= {data_ff[6:0], sda_s};
      if (wr_ctl) begin
        control_ff[CTL_EN]    <= pwdata[CTL_EN];
        control_ff[CTL_IE]    <= pwdata[CTL_IE];
        control_ff[CTL_ACKEN] <= pwdata[CTL_ACKEN];
        control_ff[CTL_STA]   <= pwdata[CTL_STA];
        control_ff[CTL_STO]   <= pwdata[CTL_STO];
      end else if (sto_done) begin
        control_ff[CTL_STO] <= 1'b0;
      end
      if (hw_flag) control_ff[CTL_FLAG] <= 1'b1;
      else if (flag_clr) control_ff[CTL_FLAG] <= 1'b0;
      if (data_col) control_ff[CTL_WCOL] <= 1'b1;
      else if (data_ok) control_ff[CTL_WCOL] <= 1'b0;
    end
  end
endmodule : twm_master
`default_nettype wire

/* File: twm_checker.sv */
`timescale 1ns/10ps
`default_nettype none
// ****
// Port checks
// ****
module twm_checker
  import twm_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        scl_out,
  input wire logic        scl_oe,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  input wire logic        irq,
  input wire logic        master_receive_mode
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  wire acc    = psel && penable;
  wire ctl_wr = acc && pwrite && paddr == ADDR_CONTROL;
  chk_ready_high: assert property (acc |-> pready)
    else $error("pready low in access");
  chk_unmapped_err: assert property (acc && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h0c))
    else $error("pslverr wrong for address");
  chk_open_drain: assert property (!scl_out && !sda_out)
    else $error("line output not zero");
  chk_word_upper: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_status_mask: assert property (acc && !pwrite && paddr == ADDR_STATUS |-> prdata[2:0] == 3'h0)
    else $error("status low bits set");
  chk_irq_mask: assert property (ctl_wr && !pwdata[CTL_IE] |=> !irq)
    else $error("irq with interrupt disabled");
  chk_flag_clear: assert property (ctl_wr && pwdata[CTL_FLAG] |=> !irq)
    else $error("flag not cleared by write");
  chk_hold_stall: assert property (irq && $past(irq) && $past(irq, 2) |-> scl_oe && $stable(sda_oe))
    else $error("bus moved while flag set");
  cover property ($rose(irq));
  cover property ($rose(master_receive_mode));
  cover property (acc && pslverr);
endmodule : twm_checker
`default_nettype wire

/* File: twm_slave.sv */
`timescale 1ns/10ps
`default_nettype none
// ****
// Slave receiver model
// ****
module twm_slave (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       ack_en,
  output var  logic       sda_low,
  output var  logic [7:0] last_byte,
  output int              stop_count
);
  logic [7:0] sh;
  int         bits;
  logic       framed;
  initial begin
    sda_low = 1'h0;
    last_byte = 8'h0;
    stop_count = 0;
    bits = 0;
    framed = 1'h0;
    sh = 8'h0;
  end
  always @(negedge sda) begin
    if (scl === 1'h1) begin
      bits = 0;
      framed = 1'h1;
    end
  end
  always @(posedge sda) begin
    if (scl === 1'h1 && framed) begin
      framed = 1'h0;
      stop_count++;
    end
  end
  always @(posedge scl) begin
    if (framed && bits < 8) begin
      sh = {sh[6:0], sda};
      bits++;
    end
  end
  always @(negedge scl) begin
    if (framed && bits == 8) begin
      last_byte = sh;
      sda_low = ack_en;
      bits = 9;
    end else if (bits == 9) begin
      sda_low = 1'h0;
      bits = 0;
    end
  end
endmodule : twm_slave
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/10ps
`default_nettype none
// ****
// Bench top
// ****
module testbench;
  import twm_pkg::*;
  logic        mclk, rst, psel, penable, pwrite, err, s_low, ack_en;
  logic [7:0]  paddr, s_byte, b;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, irq, mrm;
  wire         scl = !scl_oe;
  wire         sda = !(sda_oe || s_low);
  int          s_stops, k, bad_count, cmp_count, seed, n;
  twm_master twm_master_i (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq), .master_receive_mode(mrm));
  twm_slave twm_slave_i (.scl(scl), .sda(sda), .ack_en(ack_en), .sda_low(s_low),
    .last_byte(s_byte), .stop_count(s_stops));
  initial begin
    mclk = 1'h0;
    forever #50 mclk = ~mclk;
  end
  task automatic complete_run;
    $display("compares %0d errors %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'h1;
    @(posedge mclk);
    while (pready !== 1'h1) @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  function automatic logic [7:0] exp_st(input logic a, input logic dat);
    if (dat) return a ? ST_DATA_ACK : ST_DATA_NACK;
    return a ? ST_AW_ACK : ST_AW_NACK;
  endfunction : exp_st
  task automatic step(input logic [7:0] c, input logic [7:0] st);
    apb(1'h1, ADDR_CONTROL, c);
    @(posedge mclk);
    for (n = 0; n < 400 && irq !== 1'h1; n++) @(posedge mclk);
    chk("flag", {31'h0, irq}, 32'h1);
    apb(1'h0, ADDR_STATUS, 8'h0);
    chk("status", rd, {24'h0, st});
  endtask : step
  task automatic send(input logic [7:0] v, input logic a, input logic dat);
    ack_en <= a;
    apb(1'h1, ADDR_DATA, v);
    step(8'h85, exp_st(a, dat));
    chk("slave byte", {24'h0, s_byte}, {24'h0, v});
  endtask : send
  initial begin
    seed = 59;
    bad_count = 0;
    cmp_count = 0;
    {rst, psel, penable, pwrite, paddr, pwdata, ack_en} = {4'h8, 8'h0, 32'h0, 1'h1};
    repeat (4) @(posedge mclk);
    rst <= 1'h0;
    apb(1'h0, ADDR_CONTROL, 8'h0);
    chk("control", rd, {24'h0, CONTROL_RESET});
    apb(1'h0, ADDR_STATUS, 8'h0);
    chk("status", rd, {24'h0, ST_IDLE});
    apb(1'h0, ADDR_BITRATE, 8'h0);
    chk("bitrate", rd, {24'h0, BITRATE_RESET});
    apb(1'h1, ADDR_BITRATE, 8'h01);
    apb(1'h1, ADDR_DATA, 8'h5a);
    apb(1'h0, ADDR_CONTROL, 8'h0);
    chk("collision", {31'h0, rd[CTL_WCOL]}, 32'h1);
    apb(1'h0, ADDR_DATA, 8'h0);
    chk("data", rd, {24'h0, DATA_RESET});
    apb(1'h0, 8'h10, 8'h0);
    chk("slverr", {31'h0, err}, 32'h1);
    step(8'ha5, ST_START);
    chk("irq", {31'h0, irq}, 32'h1);
    b = 8'($random(seed));
    send({b[7:1], 1'h0}, 1'h1, 1'h0);
    chk("mode", {31'h0, mrm}, 32'h0);
    apb(1'h1, ADDR_CONTROL, 8'h04);
    @(posedge mclk);
    chk("irq", {31'h0, irq}, 32'h0);
    apb(1'h0, ADDR_CONTROL, 8'h0);
    chk("control", rd & 32'hf7, 32'h84);
    for (int i = 0; i < 5; i++) begin
      b = 8'($random(seed));
      send(b, 1'($random(seed)), 1'h1);
    end
    k = s_stops;
    step(8'ha5, ST_RSTART);
    chk("stops", s_stops, k);
    send({b[7:1], 1'h0}, 1'h0, 1'h0);
    step(8'hb5, ST_START);
    chk("stops", s_stops, k + 1);
    apb(1'h0, ADDR_CONTROL, 8'h0);
    chk("stop bit", {31'h0, rd[CTL_STO]}, 32'h0);
    send({b[7:1], 1'h0}, 1'h1, 1'h0);
    apb(1'h1, ADDR_CONTROL, 8'h95);
    for (n = 0; n < 400 && s_stops < k + 2; n++) @(posedge mclk);
    chk("stops", s_stops, k + 2);
    apb(1'h0, ADDR_CONTROL, 8'h0);
    chk("stop bit", {31'h0, rd[CTL_STO]}, 32'h0);
    step(8'ha5, ST_START);
    apb(1'h1, ADDR_DATA, {b[7:1], 1'h1});
    step(8'h85, ST_AR_ACK);
    chk("mode", {31'h0, mrm}, 32'h1);
    complete_run;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    complete_run;
  end
endmodule : testbench
bind twm_master twm_checker twm_checker_i (.mclk(mclk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .scl_out(scl_out), .scl_oe(scl_oe),
  .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq), .master_receive_mode(master_receive_mode));
`default_nettype wire
